/* flash_pattern.sv */
`timescale 1ns/10ps
module flash_pattern
  import sync_lock_pkg::*;
#(
  parameter int TICK_CYCLES = FLASH_TICK_CYCLES,
  parameter int ON_TICKS = FLASH_ON_TICKS,
  parameter int PERIOD_TICKS = FLASH_PERIOD_TICKS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  output logic led
);

  initial
  begin
    if (TICK_CYCLES < 1 || ON_TICKS < 1 || PERIOD_TICKS <= ON_TICKS)
      $error("flash_pattern: bad timing parameters");
  end

  logic [31:0] div_q, div_d;
  logic [31:0] tick_q, tick_d;
  logic led_q, led_d;
  logic tick_en;

  // Prescaler enable and pattern position
  always_comb
  begin
    tick_en = (div_q == 32'(TICK_CYCLES - 1));
    div_d = tick_en ? 32'h0 : div_q + 32'h1;
    tick_d = tick_q;
    if (tick_en)
      tick_d = (tick_q == 32'(PERIOD_TICKS - 1)) ? 32'h0 : tick_q + 32'h1;
    if (!enable)
    begin
      div_d = 32'h0;
      tick_d = 32'h0;
    end
    led_d = enable && (tick_d < 32'(ON_TICKS));
  end

  // Register the pattern
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 32'h0;
      tick_q <= 32'h0;
      led_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
      led_q <= led_d;
    end
  end

  assign led = led_q;

endmodule

/* host_model.sv */
`timescale 1ns/10ps
module host_model
  import sync_lock_pkg::*;
(
  // Clock, reset and commands
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire slave_state_type set_state,
  input wire slave_state_type set_req,
  input wire logic force_preop,
  // State seen by the block
  output slave_state_type state_q,
  output slave_state_type req_q
);
  slave_state_type state_d;
  slave_state_type req_d;
  // Loads a transition; a PreOP request from the block overrides the load
  always_comb
  begin
    state_d = load ? set_state : state_q;
    req_d = load ? set_req : req_q;
    if (force_preop)
    begin
      state_d = ST_PREOP;
      req_d = ST_PREOP;
    end
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_q <= ST_INIT;
      req_q <= ST_INIT;
    end
    else
    begin
      state_q <= state_d;
      req_q <= req_d;
    end
endmodule

/* sync_lock_chk.sv */
`timescale 1ns/10ps
module sync_lock_chk
  import sync_lock_pkg::*;
#(
  parameter int DEADLINE_CYCLES = LOCK_DEADLINE_CYCLES
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Watched ports
  input wire setup_type SETUP,
  input wire logic SYNC_START,
  input wire logic IRQ_MISSED,
  input wire logic OTHER_ERR,
  input wire logic ALARM_CLEAR,
  input wire report_type REPORT,
  input wire logic [15:0] DISPLAY_CODE,
  input wire logic ERR_LED
);
  int since_q;
  int since_d;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Cycles since the last sync start, saturating
  always_comb
    since_d = SYNC_START ? 0 : (since_q < 4 * DEADLINE_CYCLES) ? since_q + 1 : since_q;
  always_ff @(posedge REF_CLK or posedge RST)
    if (RST)
      since_q <= 0;
    else
      since_q <= since_d;
  a_no_early_alarm: assert property ($rose(REPORT.alarm) && !$past(IRQ_MISSED) && !$past(OTHER_ERR)
    |-> since_q >= DEADLINE_CYCLES - 1) else $error("Alarm before lock deadline");
  a_no_freerun: assert property ($rose(REPORT.alarm) |-> $past(SETUP.sync_mode) != SYNC_FREERUN)
    else $error("Alarm in free-run mode");
  a_miss_needs_ext: assert property ($rose(REPORT.alarm) && $past(IRQ_MISSED)
    |-> $past(SETUP.comm_extended_setup_seven[EXT_MISS_MODE_BIT])) else $error("Miss alarm without extended mode");
  a_alarm_code: assert property ($rose(REPORT.alarm) && !$past(OTHER_ERR)
    |-> REPORT.al_code == AL_CODE_INCOMPLETE_LOCK) else $error("Wrong status code with alarm");
  a_alarm_preop: assert property ($rose(REPORT.alarm) && !$past(OTHER_ERR) |-> REPORT.force_preop)
    else $error("No return to PreOP with alarm");
  a_preop_pulse: assert property (REPORT.force_preop |=> !REPORT.force_preop)
    else $error("PreOP request longer than one cycle");
  a_clear_only: assert property ($fell(REPORT.alarm) |-> $past(ALARM_CLEAR))
    else $error("Alarm dropped without clear");
  a_display_first: assert property (REPORT.alarm && $past(REPORT.alarm) && !$past(ALARM_CLEAR)
    |-> $stable(DISPLAY_CODE)) else $error("Display changed while alarm held");
  a_led_dark: assert property (!REPORT.alarm [*4] |-> !ERR_LED)
    else $error("Indicator lit without alarm");
  c_deadline: cover property ($rose(REPORT.alarm) && !$past(IRQ_MISSED));
  c_miss: cover property ($rose(REPORT.alarm) && $past(IRQ_MISSED));
  c_clear: cover property ($fell(REPORT.alarm));
endmodule
bind sync_lock_supervisor sync_lock_chk #(.DEADLINE_CYCLES(DEADLINE_CYCLES)) chk (.REF_CLK, .RST, .SETUP,
  .SYNC_START, .IRQ_MISSED, .OTHER_ERR, .ALARM_CLEAR, .REPORT, .DISPLAY_CODE, .ERR_LED);

/* sync_lock_pkg.sv */
package sync_lock_pkg;

  // Timing: 100 MHz reference clock
  localparam int CLK_PERIOD_NS = 10;
  // Lock must be reached one second after the sync process starts
  localparam int LOCK_DEADLINE_MS = 1000;
  localparam int LOCK_DEADLINE_CYCLES = (LOCK_DEADLINE_MS * 1000000) / CLK_PERIOD_NS;

  // Extended setup and consecutive-error setting field positions
  localparam int EXT_SETUP_WIDTH = 16;
  localparam int EXT_MISS_MODE_BIT = 8;
  localparam int MAX_ERR_WIDTH = 16;
  localparam int MAX_ERR_LSB = 0;
  localparam int MAX_ERR_FIELD_WIDTH = 4;

  // Status code reported with the alarm
  localparam logic [15:0] AL_CODE_INCOMPLETE_LOCK = 16'h002d;
  localparam logic [15:0] AL_CODE_NONE = 16'h0000;

  // Single-flash indicator timing: 200 ms on, 1000 ms off
  localparam int FLASH_ON_MS = 200;
  localparam int FLASH_OFF_MS = 1000;
  localparam int FLASH_TICK_US = 1;
  localparam int FLASH_TICK_CYCLES = (FLASH_TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int FLASH_ON_TICKS = FLASH_ON_MS * 1000 / FLASH_TICK_US;
  localparam int FLASH_PERIOD_TICKS = (FLASH_ON_MS + FLASH_OFF_MS) * 1000 / FLASH_TICK_US;

  // Slave state machine states
  typedef enum logic [2:0] {
    ST_INIT,
    ST_PREOP,
    ST_SAFEOP,
    ST_OP,
    ST_BOOT
  } slave_state_type;

  // Synchronisation modes
  typedef enum logic [1:0] {
    SYNC_FREERUN,
    SYNC_DC,
    SYNC_SM2
  } sync_mode_type;

  // Supervisor state
  typedef enum logic [1:0] {
    SUP_IDLE,
    SUP_WAIT_LOCK,
    SUP_LOCKED
  } sup_state_type;

  // Settings from the host
  typedef struct packed {
    logic [EXT_SETUP_WIDTH-1:0] comm_extended_setup_seven;
    logic [MAX_ERR_WIDTH-1:0] max_consecutive_comm_error_setting;
    sync_mode_type sync_mode;
  } setup_type;

  // Report toward the host
  typedef struct packed {
    logic alarm;
    logic force_preop;
    logic [15:0] al_code;
  } report_type;

endpackage

/* sync_lock_supervisor.sv */
`timescale 1ns/10ps
module sync_lock_supervisor
  import sync_lock_pkg::*;
#(
  parameter int DEADLINE_CYCLES = LOCK_DEADLINE_CYCLES,
  parameter int FLASH_TICK = FLASH_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Slave state and configuration
  input wire slave_state_type STATE,
  input wire slave_state_type REQ_STATE,
  input wire setup_type SETUP,
  // Synchronisation events (same clock domain)
  input wire logic SYNC_START,
  input wire logic LOCK_DONE,
  input wire logic IRQ_HANDLED,
  input wire logic IRQ_MISSED,
  // Other communication errors and clear
  input wire logic OTHER_ERR,
  input wire logic [15:0] OTHER_ERR_CODE,
  input wire logic ALARM_CLEAR,
  // Outputs
  output report_type REPORT,
  output logic [15:0] DISPLAY_CODE,
  output logic ERR_LED
);

  initial
  begin
    if (DEADLINE_CYCLES < 1)
      $error("sync_lock_supervisor: deadline must be at least one cycle");
    if (FLASH_TICK < 1)
      $error("sync_lock_supervisor: indicator tick must be at least one cycle");
  end

  // Threshold field of the consecutive-error setting
  function automatic logic [MAX_ERR_FIELD_WIDTH-1:0] miss_limit(input setup_type s);
    miss_limit = s.max_consecutive_comm_error_setting[MAX_ERR_LSB +: MAX_ERR_FIELD_WIDTH];
  endfunction

  sup_state_type sup_q, sup_d;
  logic [31:0] timer_q, timer_d;
  logic [MAX_ERR_FIELD_WIDTH:0] miss_q, miss_d;
  logic alarm_q, alarm_d;
  logic [15:0] code_q, code_d;
  logic [15:0] disp_q, disp_d;
  logic preop_q, preop_d;
  logic ext_mode;
  logic mode_ok;
  logic window_ok;
  logic deadline_hit;
  logic miss_hit;
  logic detect;

  // Qualifiers for detection
  always_comb
  begin
    ext_mode = SETUP.comm_extended_setup_seven[EXT_MISS_MODE_BIT];
    mode_ok = (SETUP.sync_mode == SYNC_DC) || (SETUP.sync_mode == SYNC_SM2);
    window_ok = 1'b0;
    if (STATE == ST_PREOP && REQ_STATE == ST_SAFEOP)
      window_ok = 1'b1;
    else if (ext_mode && STATE == ST_SAFEOP && REQ_STATE == ST_OP)
      window_ok = 1'b1;
    else if (ext_mode && (STATE == ST_SAFEOP || STATE == ST_OP))
      window_ok = 1'b1;
  end

  // Lock supervisor sequence
  always_comb
  begin
    sup_d = sup_q;
    timer_d = timer_q;
    miss_d = miss_q;
    deadline_hit = 1'b0;
    miss_hit = 1'b0;
    case (sup_q)
      SUP_IDLE:
      begin
        timer_d = 32'h0;
        miss_d = '0;
      end
      SUP_WAIT_LOCK:
      begin
        if (LOCK_DONE)
        begin
          sup_d = SUP_LOCKED;
          miss_d = '0;
        end
        else if (timer_q == 32'(DEADLINE_CYCLES - 1))
        begin
          deadline_hit = 1'b1;
          sup_d = SUP_IDLE;
        end
        else
          timer_d = timer_q + 32'h1;
      end
      SUP_LOCKED:
      begin
        if (IRQ_HANDLED)
          miss_d = '0;
        else if (IRQ_MISSED && ext_mode)
        begin
          if (miss_q > {1'b0, miss_limit(SETUP)} - 1'b1 || miss_q == {1'b0, miss_limit(SETUP)})
          begin
            miss_hit = (miss_q + 1'b1) > {1'b0, miss_limit(SETUP)};
          end
          if (miss_q != '1)
            miss_d = miss_q + 1'b1;
          if (miss_hit)
            sup_d = SUP_IDLE;
        end
      end
      default:
        sup_d = SUP_IDLE;
    endcase
    if (SYNC_START)
    begin
      sup_d = SUP_WAIT_LOCK;
      timer_d = 32'h0;
      miss_d = '0;
    end
    else if (!mode_ok)
      sup_d = SUP_IDLE;
  end

  // Alarm, report code and display
  always_comb
  begin
    detect = (deadline_hit || miss_hit) && mode_ok && window_ok;
    alarm_d = alarm_q;
    code_d = code_q;
    disp_d = disp_q;
    preop_d = 1'b0;
    if (ALARM_CLEAR)
    begin
      alarm_d = 1'b0;
      code_d = AL_CODE_NONE;
      disp_d = AL_CODE_NONE;
    end
    if (OTHER_ERR)
    begin
      code_d = OTHER_ERR_CODE;
      if (disp_d == AL_CODE_NONE)
        disp_d = OTHER_ERR_CODE;
    end
    if (detect)
    begin
      alarm_d = 1'b1; // set wins over clear
      preop_d = 1'b1;
      code_d = AL_CODE_INCOMPLETE_LOCK;
      if (disp_d == AL_CODE_NONE)
        disp_d = AL_CODE_INCOMPLETE_LOCK;
    end
  end

  // Register the lock supervisor sequence
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sup_q <= SUP_IDLE;
      timer_q <= 32'h0;
      miss_q <= '0;
    end
    else
    begin
      sup_q <= sup_d;
      timer_q <= timer_d;
      miss_q <= miss_d;
    end
  end

  // Register alarm, report code and display
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      alarm_q <= 1'b0;
      code_q <= AL_CODE_NONE;
      disp_q <= AL_CODE_NONE;
      preop_q <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_d;
      code_q <= code_d;
      disp_q <= disp_d;
      preop_q <= preop_d;
    end
  end

  // Single-flash indicator while alarm stands
  flash_pattern #(
    .TICK_CYCLES(FLASH_TICK),
    .ON_TICKS(FLASH_ON_TICKS),
    .PERIOD_TICKS(FLASH_PERIOD_TICKS)
  ) u_flash (
    .clk(REF_CLK),
    .rst(RST),
    .enable(alarm_q),
    .led(ERR_LED)
  );

  assign REPORT.alarm = alarm_q;
  assign REPORT.force_preop = preop_q;
  assign REPORT.al_code = code_q;
  assign DISPLAY_CODE = disp_q;

endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import sync_lock_pkg::*;
  localparam int D = 50;
  logic clk = 0;
  logic rst = 1;
  logic load = 0;
  logic oerr = 0;
  logic [15:0] ocode = '0;
  logic [4:0] ev = '0;
  slave_state_type ss = ST_INIT;
  slave_state_type sr = ST_INIT;
  slave_state_type st;
  slave_state_type rq;
  setup_type setup = '0;
  report_type rep;
  logic [15:0] disp;
  logic led;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  host_model host (.clk(clk), .rst(rst), .load(load), .set_state(ss), .set_req(sr),
    .force_preop(rep.force_preop), .state_q(st), .req_q(rq));
  sync_lock_supervisor #(.DEADLINE_CYCLES(D), .FLASH_TICK(1)) dut (.REF_CLK(clk), .RST(rst), .STATE(st),
    .REQ_STATE(rq), .SETUP(setup), .SYNC_START(ev[4]), .LOCK_DONE(ev[3]), .IRQ_HANDLED(ev[2]),
    .IRQ_MISSED(ev[1]), .OTHER_ERR(oerr), .OTHER_ERR_CODE(ocode), .ALARM_CLEAR(ev[0]),
    .REPORT(rep), .DISPLAY_CODE(disp), .ERR_LED(led));
  task close_out;
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task fire(input logic [4:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask
  task alarm_is(input logic exp);
    chk("alarm", {15'h0, exp}, {15'h0, rep.alarm});
  endtask
  // Loads mode and transition, threshold 2, then starts sync
  task start(input sync_mode_type m, input logic ext, input slave_state_type s, input slave_state_type r);
    @(posedge clk);
    setup <= {7'h0, ext, 8'h0, 16'h0002, m};
    ss <= s;
    sr <= r;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    fire(5'h10);
  endtask
  // Lock never reached, restart near the deadline, then a later error
  task t_deadline;
    start(SYNC_DC, 1'b0, ST_PREOP, ST_SAFEOP);
    tick(D - 3);
    alarm_is(1'b0);
    fire(5'h10);
    tick(D - 2);
    alarm_is(1'b0);
    tick(4);
    alarm_is(1'b1);
    chk("code", 16'h002d, rep.al_code);
    chk("state", {13'h0, ST_PREOP}, {13'h0, st});
    chk("request", {13'h0, ST_PREOP}, {13'h0, rq});
    chk("led", 16'h0001, {15'h0, led});
    @(posedge clk);
    oerr <= 1'b1;
    ocode <= 16'h0011;
    @(posedge clk);
    oerr <= 1'b0;
    tick(1);
    chk("code", 16'h0011, rep.al_code);
    chk("display", 16'h002d, disp);
    fire(5'h01);
    tick(1);
    alarm_is(1'b0);
    chk("led", 16'h0000, {15'h0, led});
  endtask
  // Cases where no alarm may come
  task t_quiet(input sync_mode_type m, input slave_state_type s, input slave_state_type r, input logic lk);
    start(m, 1'b0, s, r);
    if (lk)
      fire(5'h08);
    repeat (4) fire(5'h02);
    tick(D + 4);
    alarm_is(1'b0);
  endtask
  // Misses after lock, with a handled interrupt resetting the count between runs
  task t_miss;
    start(SYNC_SM2, 1'b1, ST_SAFEOP, ST_OP);
    fire(5'h08);
    repeat (2) fire(5'h02);
    fire(5'h04);
    repeat (2) fire(5'h02);
    tick(2);
    alarm_is(1'b0);
    fire(5'h02);
    tick(1);
    alarm_is(1'b1);
    chk("code", 16'h002d, rep.al_code);
    chk("display", 16'h002d, disp);
    fire(5'h01);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk("code", 16'h0000, rep.al_code);
    t_deadline;
    t_quiet(SYNC_FREERUN, ST_PREOP, ST_SAFEOP, 1'b0);
    t_quiet(SYNC_DC, ST_PREOP, ST_SAFEOP, 1'b1);
    t_quiet(SYNC_DC, ST_SAFEOP, ST_OP, 1'b0);
    t_miss;
    close_out;
  end
  // Watchdog
  initial
  begin
    #100us;
    error_cnt++;
    close_out;
  end
endmodule
